// ### logic/ptc_defines.vh
// Function
// - bit 7 picks PRBS15 or quasi-random pattern
// - switch clear: transmit side generates toward line
// - switch set: receive side generates to backplane
// - inject rising edge flips exactly one bit
// - injection only acts while generator enabled
// - error lands on the active generator output
// - invert, switch clear: line out, receive check
// - invert, switch set: backplane out, transmit check
// - bit 4 reads checker lock state
// - switch clear: check line data for pattern
// - switch set: check transmit backplane data
// - bit 2 enables generator toward line side
// - switch set: generator drives receive backplane
// - bit 1 puts receive framer in bypass
// - bit 0 puts transmit framer in bypass
`ifndef PTC_DEFINES_VH
`define PTC_DEFINES_VH
`define PTC_ADDR_CSR      4'h0
`define PTC_ADDR_SWITCH   4'h4
`define PTC_CSR_RESET     8'h00
`define PTC_BIT_TYPE      7
`define PTC_BIT_INJECT    6
`define PTC_BIT_INVERT    5
`define PTC_BIT_LOCK      4
`define PTC_BIT_CHK_EN    3
`define PTC_BIT_GEN_EN    2
`define PTC_BIT_RX_SKIP   1
`define PTC_BIT_TX_SKIP   0
`define PTC_BIT_SWITCH    3
`define PTC_LOCK_GOOD     8'd32
`define PTC_LOCK_BAD      8'd4
`define PTC_FIFO_DEPTH    32
`endif

// ### logic/ptc_fifo.v
`timescale 1ns/1ps
`default_nettype none
module ptc_fifo #(
  parameter WIDTH = 1,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             sys_clk,   // clock
  input  wire             rstn,      // async reset, low
  input  wire [WIDTH-1:0] in_data,   // write data
  input  wire             in_valid,  // write request
  output wire             in_ready,  // not full
  output wire [WIDTH-1:0] out_data,  // head data
  output wire             out_valid, // not empty
  input  wire             out_ready  // drain
);
  localparam [AW:0] FULL = DEPTH;
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            do_wr;
  wire            do_rd;
  assign in_ready  = (count != FULL);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign do_wr     = in_valid & in_ready;
  assign do_rd     = out_valid & out_ready;
  always @(posedge sys_clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) wr_ptr <= wr_ptr + 1'b1;
      if (do_rd) rd_ptr <= rd_ptr + 1'b1;
      if (do_wr && !do_rd) count <= count + 1'b1;
      else if (do_rd && !do_wr) count <= count - 1'b1;
    end
  end
endmodule // ptc_fifo
`default_nettype wire

// ### logic/ptc_pattern_test.v
`timescale 1ns/1ps
`default_nettype none
`include "ptc_defines.vh"
module ptc_pattern_test (
  input  wire        sys_clk,        // 50 MHz clock
  input  wire        rstn,           // async reset, low
  input  wire [31:0] haddr,          // ahb address
  input  wire [1:0]  htrans,         // ahb transfer type
  input  wire        hwrite,         // ahb write
  input  wire [2:0]  hsize,          // ahb size
  input  wire [31:0] hwdata,         // ahb write data
  input  wire        hsel,           // ahb select
  input  wire        hready,         // ahb bus ready
  output reg  [31:0] hrdata,         // ahb read data
  output reg         hreadyout,      // ahb slave ready
  output reg         hresp,          // ahb response, always okay
  input  wire        line_rx_bit,    // receive line data (pin)
  input  wire        line_rx_stb,    // receive bit strobe (pin)
  input  wire        bp_tx_bit,      // transmit backplane data (pin)
  input  wire        bp_tx_stb,      // transmit backplane strobe (pin)
  input  wire        tx_bit_tick,    // transmit bit slot, same clock
  input  wire        rx_bit_tick,    // receive backplane bit slot, same clock
  output reg         line_tx_bit,    // pattern toward line
  output reg         line_tx_active, // line pattern valid
  output reg         bp_rx_bit,      // pattern onto receive backplane
  output reg         bp_rx_active,   // backplane pattern valid
  output reg         rx_framer_skip, // receive framer bypass
  output reg         tx_framer_skip  // transmit framer bypass
);
  reg  [7:0]  csr;
  reg         path_switch;
  reg         lock;
  reg         ap_valid;
  reg         ap_write;
  reg  [3:0]  ap_addr;
  reg  [14:0] gen_lfsr;
  reg  [19:0] gen_qrss;
  reg         inject_prev;
  reg         inject_pend;
  reg  [1:0]  rx_sync_a;
  reg  [1:0]  rx_sync_b;
  reg  [1:0]  tx_sync_a;
  reg  [1:0]  tx_sync_b;
  reg         rx_stb_prev;
  reg         tx_stb_prev;
  reg  [19:0] chk_shift;
  reg  [7:0]  good_cnt;
  reg  [7:0]  bad_cnt;
  reg  [7:0]  next_csr;
  wire        sel_qrss;
  wire        gen_en;
  wire        chk_en;
  wire        invert;
  wire        gen_tick;
  wire        gen_raw;
  wire        gen_out;
  wire        chk_in_bit;
  wire        chk_in_stb;
  wire        chk_bit;
  wire        expect_bit;
  wire        fifo_in_ready;
  wire        fifo_out_valid;
  wire        fifo_out_data;
  wire        fifo_pop;
  assign sel_qrss = csr[`PTC_BIT_TYPE];
  assign gen_en   = csr[`PTC_BIT_GEN_EN];
  assign chk_en   = csr[`PTC_BIT_CHK_EN];
  assign invert   = csr[`PTC_BIT_INVERT];

  // register bus: zero wait states, one okay cycle per transfer
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr  <= 4'h0;
    end else if (hready) begin
      ap_valid <= hsel & htrans[1];
      ap_write <= hwrite;
      ap_addr  <= haddr[3:0];
    end
  end

  always @* begin
    next_csr = csr;
    if (ap_valid && ap_write && ap_addr == `PTC_ADDR_CSR) begin
      next_csr = hwdata[7:0];
    end
    next_csr[`PTC_BIT_LOCK] = lock;
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      csr         <= `PTC_CSR_RESET;
      path_switch <= 1'b0;
      hrdata      <= 32'h0000_0000;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end else begin
      csr <= next_csr;
      if (ap_valid && ap_write && ap_addr == `PTC_ADDR_SWITCH) begin
        path_switch <= hwdata[`PTC_BIT_SWITCH];
      end
      // read data is set up during the address phase for the next cycle
      if (hready && hsel && htrans[1] && !hwrite) begin
        case (haddr[3:0])
          `PTC_ADDR_CSR:    hrdata <= {24'h000000, next_csr};
          `PTC_ADDR_SWITCH: hrdata <= {28'h0000000, path_switch, 3'h0};
          default:          hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // pin inputs pass two flops before use
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rx_sync_a   <= 2'h0;
      rx_sync_b   <= 2'h0;
      tx_sync_a   <= 2'h0;
      tx_sync_b   <= 2'h0;
      rx_stb_prev <= 1'b0;
      tx_stb_prev <= 1'b0;
    end else begin
      rx_sync_a   <= {line_rx_stb, line_rx_bit};
      rx_sync_b   <= rx_sync_a;
      tx_sync_a   <= {bp_tx_stb, bp_tx_bit};
      tx_sync_b   <= tx_sync_a;
      rx_stb_prev <= rx_sync_b[1];
      tx_stb_prev <= tx_sync_b[1];
    end
  end

  // generator: one engine, routed by the path switch
  assign gen_tick = path_switch ? rx_bit_tick : tx_bit_tick;
  assign gen_raw  = sel_qrss ? gen_qrss[19] : gen_lfsr[14];
  assign gen_out  = (gen_raw ^ invert ^ inject_pend);

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      gen_lfsr    <= 15'h7fff;
      gen_qrss    <= 20'hfffff;
      inject_prev <= 1'b0;
      inject_pend <= 1'b0;
    end else begin
      inject_prev <= csr[`PTC_BIT_INJECT];
      if (!gen_en) begin
        inject_pend <= 1'b0;
      end else if (csr[`PTC_BIT_INJECT] && !inject_prev) begin
        inject_pend <= 1'b1;
      end else if (gen_tick) begin
        inject_pend <= 1'b0;
      end
      if (gen_en && gen_tick) begin
        gen_lfsr <= {gen_lfsr[13:0], gen_lfsr[14] ^ gen_lfsr[13]};
        gen_qrss <= {gen_qrss[18:0], gen_qrss[19] ^ gen_qrss[16]};
      end
    end
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      line_tx_bit    <= 1'b0;
      line_tx_active <= 1'b0;
      bp_rx_bit      <= 1'b0;
      bp_rx_active   <= 1'b0;
      rx_framer_skip <= 1'b0;
      tx_framer_skip <= 1'b0;
    end else begin
      rx_framer_skip <= csr[`PTC_BIT_RX_SKIP];
      tx_framer_skip <= csr[`PTC_BIT_TX_SKIP];
      line_tx_active <= gen_en & ~path_switch;
      bp_rx_active   <= gen_en & path_switch;
      if (gen_en && gen_tick && !path_switch) line_tx_bit <= gen_out;
      if (gen_en && gen_tick && path_switch)  bp_rx_bit   <= gen_out;
      if (!gen_en) begin
        line_tx_bit <= 1'b0;
        bp_rx_bit   <= 1'b0;
      end
    end
  end

  // checker input buffered so bursts from the pin side are not lost
  assign chk_in_bit = path_switch ? tx_sync_b[0] : rx_sync_b[0];
  assign chk_in_stb = path_switch ? (tx_sync_b[1] & ~tx_stb_prev) : (rx_sync_b[1] & ~rx_stb_prev);
  assign fifo_pop   = fifo_out_valid;

  ptc_fifo #(.WIDTH(1), .DEPTH(`PTC_FIFO_DEPTH), .AW(5)) u_chk_fifo (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .in_data   (chk_in_bit),
    .in_valid  (chk_in_stb & chk_en & fifo_in_ready),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop)
  );

  assign chk_bit    = fifo_out_data ^ invert;
  assign expect_bit = sel_qrss ? (chk_shift[19] ^ chk_shift[16]) : (chk_shift[14] ^ chk_shift[13]);

  // self-synchronising checker: lock after a run of predicted bits
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      chk_shift <= 20'h00000;
      good_cnt  <= 8'h00;
      bad_cnt   <= 8'h00;
      lock      <= 1'b0;
    end else if (!chk_en) begin
      good_cnt <= 8'h00;
      bad_cnt  <= 8'h00;
      lock     <= 1'b0;
    end else if (fifo_pop) begin
      chk_shift <= {chk_shift[18:0], chk_bit};
      if (chk_bit == expect_bit) begin
        bad_cnt <= 8'h00;
        if (good_cnt != `PTC_LOCK_GOOD) good_cnt <= good_cnt + 8'h01;
        if (good_cnt == `PTC_LOCK_GOOD - 8'h01) lock <= 1'b1;
      end else begin
        good_cnt <= 8'h00;
        bad_cnt  <= bad_cnt + 8'h01;
        if (bad_cnt == `PTC_LOCK_BAD - 8'h01) begin
          lock    <= 1'b0;
          bad_cnt <= 8'h00;
        end
      end
    end
  end
endmodule // ptc_pattern_test
`default_nettype wire

// ### tb/ptc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ptc_checker (
  input wire logic        sys_clk,        // clock
  input wire logic        rstn,           // reset
  input wire logic [31:0] haddr,          // address
  input wire logic [1:0]  htrans,         // type
  input wire logic        hwrite,         // write
  input wire logic [31:0] hwdata,         // wdata
  input wire logic        hsel,           // select
  input wire logic        hready,         // ready
  input wire logic [31:0] hrdata,         // rdata
  input wire logic        tx_bit_tick,    // slot
  input wire logic        line_tx_bit,    // line bit
  input wire logic        line_tx_active, // line on
  input wire logic        bp_rx_bit,      // bp bit
  input wire logic        bp_rx_active,   // bp on
  input wire logic        rx_framer_skip, // rx skip
  input wire logic        tx_framer_skip  // tx skip
);
  logic       ap, w, wc, rc;
  logic [3:0] a, q;
  logic [7:0] csr, sw;
  assign wc = ap && w && a == 4'h0;
  assign rc = ap && !w && a == 4'h0;
  // q counts quiet cycles since a write, so outputs may settle first
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn) begin
      {ap, w, a, q, csr, sw} <= '0;
    end else begin
      ap <= hsel && htrans[1] && hready;
      w <= hwrite;
      a <= haddr[3:0];
      q <= (ap && w) ? 4'h0 : q + {3'h0, q != 4'hf};
      if (wc) csr <= hwdata[7:0] & 8'hef;
      if (ap && w && a == 4'h4) sw <= hwdata[7:0];
    end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_tx_skip: assert property (wc |-> ##[1:2] tx_framer_skip == csr[0])
    else $error("tx bypass wrong");
  a_rx_skip: assert property (wc |-> ##[1:2] rx_framer_skip == csr[1])
    else $error("rx bypass wrong");
  a_line_route: assert property (q > 4'h3 |-> line_tx_active == (csr[2] && !sw[3]))
    else $error("line generator state wrong");
  a_bp_route: assert property (q > 4'h3 |-> bp_rx_active == (csr[2] && sw[3]))
    else $error("backplane generator state wrong");
  a_gen_quiet: assert property (q > 4'h3 && !csr[2] |-> !line_tx_bit && !bp_rx_bit)
    else $error("output moves with generator off");
  a_line_hold: assert property (q > 4'h3 && line_tx_active && $past(line_tx_active) &&
    !$past(tx_bit_tick) && !$past(tx_bit_tick, 2) |-> $stable(line_tx_bit))
    else $error("line bit changed between slots");
  a_csr_read: assert property (rc |-> hrdata[7:5] == csr[7:5] && hrdata[3:0] == csr[3:0])
    else $error("control read back wrong");
  a_lock_off: assert property (rc && !csr[3] && q > 4'h3 |-> !hrdata[4])
    else $error("lock with checker off");
endmodule // ptc_checker
bind ptc_pattern_test ptc_checker u_chk (.sys_clk(sys_clk), .rstn(rstn), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hsel(hsel), .hready(hready), .hrdata(hrdata), .tx_bit_tick(tx_bit_tick),
  .line_tx_bit(line_tx_bit), .line_tx_active(line_tx_active), .bp_rx_bit(bp_rx_bit),
  .bp_rx_active(bp_rx_active), .rx_framer_skip(rx_framer_skip), .tx_framer_skip(tx_framer_skip));
`default_nettype wire

// ### tb/ptc_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module ptc_far_end (
  input  wire logic sys_clk,        // clock
  input  wire logic rstn,           // reset
  input  wire logic slow,           // 16-cycle slots
  input  wire logic line_tx_bit,    // line bit
  input  wire logic line_tx_active, // line on
  input  wire logic bp_rx_bit,      // bp bit
  input  wire logic bp_rx_active,   // bp on
  output logic      tx_bit_tick,    // line slot
  output logic      rx_bit_tick,    // bp slot
  output logic      line_rx_bit,    // looped line
  output logic      line_rx_stb,    // line strobe
  output logic      bp_tx_bit,      // looped bp
  output logic      bp_tx_stb       // bp strobe
);
  logic [3:0] c;
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn) begin
      {c, tx_bit_tick, rx_bit_tick, line_rx_bit, line_rx_stb, bp_tx_bit, bp_tx_stb} <= '0;
    end else begin
      c <= (c == (slow ? 4'hf : 4'h7)) ? 4'h0 : c + 4'h1;
      tx_bit_tick <= c == 4'h0;
      rx_bit_tick <= c == 4'h0;
      // idle data toggles so a stale bit never passes for pattern
      if (c == 4'h4) begin
        line_rx_bit <= line_tx_active ? line_tx_bit : !line_rx_bit;
        bp_tx_bit <= bp_rx_active ? bp_rx_bit : !bp_tx_bit;
      end
      line_rx_stb <= line_tx_active && c > 4'h4 && c < 4'h8;
      bp_tx_stb <= bp_rx_active && c > 4'h4 && c < 4'h8;
    end
endmodule // ptc_far_end
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        sys_clk = 0, rstn = 0, hwrite = 0, slow = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd;
  logic [1:0]  htrans = 0;
  wire  [31:0] hrdata;
  wire         hrdy, hrsp, lrb, lrs, btb, bts, tt, rt, ltb, lta, bpb, bpa, rxs, txs;
  int          fails = 0, compares = 0, v;
  always #10 sys_clk = ~sys_clk;
  ptc_pattern_test u_dut (.sys_clk(sys_clk), .rstn(rstn), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hsel(1'b1), .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy), .hresp(hrsp),
    .line_rx_bit(lrb), .line_rx_stb(lrs), .bp_tx_bit(btb), .bp_tx_stb(bts), .tx_bit_tick(tt), .rx_bit_tick(rt),
    .line_tx_bit(ltb), .line_tx_active(lta), .bp_rx_bit(bpb), .bp_rx_active(bpa), .rx_framer_skip(rxs),
    .tx_framer_skip(txs));
  ptc_far_end u_far (.sys_clk(sys_clk), .rstn(rstn), .slow(slow), .line_tx_bit(ltb), .line_tx_active(lta),
    .bp_rx_bit(bpb), .bp_rx_active(bpa), .tx_bit_tick(tt), .rx_bit_tick(rt), .line_rx_bit(lrb),
    .line_rx_stb(lrs), .bp_tx_bit(btb), .bp_tx_stb(bts));
  task chk(string n, logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task bus(logic [31:0] a, d, logic w);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge sys_clk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask
  // counts bits breaking b[i] = b[i-t1]^b[i-t2]^inv; early bits skipped as the generator may start late
  task cap(int t1, t2, logic inv, bp, logic [7:0] wv);
    logic [79:0] b;
    v = 0;
    for (int i = 0; i < 80; i++) begin
      do @(posedge sys_clk); while ((bp ? rt : tt) !== 1'b1);
      repeat (2) @(posedge sys_clk);
      if (i == 40 && wv != 0) bus(0, wv, 1);
      #1 b[i] = bp ? bpb : ltb;
      if (i > 24 && b[i] !== (b[i - t1] ^ b[i - t2] ^ inv)) v++;
    end
  endtask
  task t_regs;
    bus(0, 0, 0);
    chk("csr reset", rd, 0);
    chk("okay resp", hrsp, 0);
    bus(0, 8'h13, 1);
    repeat (3) @(posedge sys_clk);
    chk("skip on", {rxs, txs}, 3);
    bus(8, 8'hff, 1);
    bus(8, 0, 0);
    chk("unmapped", rd, 0);
    bus(0, 0, 0);
    chk("lock ro", rd[7:0], 8'h03);
    bus(0, 8'h01, 1);
    repeat (3) @(posedge sys_clk);
    chk("rx skip off", {rxs, txs}, 1);
    $display("regs done");
  endtask
  task t_line;
    bus(4, 0, 1);
    bus(0, 8'h0c, 1);
    // the checker must hold lock before the injected error arrives
    repeat (600) @(posedge sys_clk);
    cap(14, 15, 0, 0, 8'h4c);
    chk("inject line", v, 3);
    chk("route line", {lta, bpa}, 2);
    bus(0, 0, 0);
    chk("lock line", rd[4], 1);
    bus(0, 8'h2c, 1);
    cap(14, 15, 1, 0, 0);
    chk("invert line", v, 0);
    bus(0, 0, 0);
    chk("lock invert", rd[4], 1);
    slow <= 1;
    bus(0, 8'h8c, 1);
    cap(17, 20, 0, 0, 0);
    chk("qrts", v, 0);
    cap(14, 15, 0, 0, 0);
    chk("qrts not prbs", v > 0, 1);
    slow <= 0;
    $display("line done");
  endtask
  task t_back;
    bus(4, 8'h08, 1);
    bus(0, 8'h2c, 1);
    repeat (600) @(posedge sys_clk);
    cap(14, 15, 1, 1, 8'h6c);
    chk("inject back", v, 3);
    chk("route back", {lta, bpa}, 1);
    bus(0, 0, 0);
    chk("lock back", rd[4], 1);
    bus(0, 8'h04, 1);
    repeat (2) @(posedge sys_clk);
    bus(0, 0, 0);
    chk("lock off", rd[4], 0);
    bus(0, 8'h40, 1);
    repeat (40) @(posedge sys_clk);
    chk("idle inject", {ltb, bpb}, 0);
    bus(0, 8'h44, 1);
    cap(14, 15, 0, 1, 0);
    chk("no late inject", v, 0);
    $display("back done");
  endtask
  task results;
    $display("fails %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    rstn <= 1;
    t_regs;
    t_line;
    t_back;
    results;
  end
  initial begin
    #400000;
    fails++;
    results;
  end
endmodule // tb_top
`default_nettype wire
